// ===== rtl/mnx_exec.sv
// execution datapath for multiply-by-file, negate-file and idle instructions
`default_nettype none
// Notes on behaviour
// - a word whose top seven bits are 0000001 is the multiply-accumulator-by-file instruction.
// - the multiply treats accumulator and file byte as unsigned.
// - the 16-bit product goes high byte to product_high_byte and low byte to product_low_byte.
// - the multiply leaves accumulator, file register and all flags untouched.
// - bank bit 0 selects the access bank, bank bit 1 takes the upper address from bank_pointer.
// - with the extended set on, bank bit 0 and address up to 95 use indexed literal offset mode.
// - a word whose top seven bits are 0110110 is negate, computing inverted file byte plus one.
// - the negate result is written back to the very location that supplied the operand.
module mnx_exec
    import mnx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction and core state
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] accum,
    input wire logic [3:0] bank_pointer,
    input wire logic extended_set,
    input wire logic [11:0] index_base,
    // data memory read
    output logic [11:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    // data memory write
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    // results
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic [4:0] flags,
    output logic [4:0] flags_wr_mask,
    output logic [3:0] phase,
    output logic instr_done
);
    // ==========================================
    // decode
    // the word is decoded while the sequencer sits in Q1; only the
    // captured copy in iw_q steers the later phases, so the caller may
    // change instr_word as soon as the word has been taken
    logic is_mul, is_neg, is_idle;
    logic [7:0] faddr;
    mnx_amode_type amode;
    logic [11:0] ea;
    assign faddr = instr_word[7:0];
    assign is_mul = instr_word[15:9] == MNX_OP_MUL;
    assign is_neg = instr_word[15:9] == MNX_OP_NEG;
    assign is_idle = (instr_word == MNX_OP_IDLE_ZERO) || (instr_word[15:12] == MNX_OP_IDLE_HI);

    // effective address of the file operand:
    // bank bit 1 - bank_pointer supplies the upper four address bits
    // bank bit 0 - access bank: lower half maps to 000h..07Fh, upper
    //              half to the special-register window F80h..FFFh
    // extended set, bank bit 0 and a small address - indexed from
    //              index_base, which takes priority over the access bank
    always_comb begin
        if (instr_word[MNX_BANK_BIT]) begin
            amode = MNX_AM_BANKED;
            ea = {bank_pointer, faddr};
        end else if (extended_set && faddr <= MNX_INDEX_LIMIT) begin
            amode = MNX_AM_INDEXED;
            ea = index_base + {4'h0, faddr};
        end else begin
            amode = MNX_AM_ACCESS;
            ea = faddr[7] ? {4'hF, faddr} : {4'h0, faddr};
        end
    end

    // ==========================================
    // phase sequencer and latched operands
    // Q1 decodes and captures, Q2 reads the file operand, Q3 forms the
    // result and Q4 writes it; every instruction takes all four phases,
    // so an idle or undecoded word costs the same four clocks as a
    // multiply or a negate
    mnx_phase_type ph_q, ph_d;
    logic [15:0] iw_q, iw_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] opnd_q, opnd_d, acc_q, acc_d;
    logic busy_q, busy_d;
    logic rd_q, rd_d, wr_q, wr_d, done_q, done_d;
    logic [7:0] wdat_q, wdat_d, ph_hi_q, ph_hi_d, pl_q, pl_d;
    logic [4:0] fl_q, fl_d, fm_q, fm_d;
    logic [15:0] prod;
    logic [8:0] neg_full;
    logic [4:0] neg_half;
    logic [7:0] neg_res;
    logic iw_mul, iw_neg;

    assign iw_mul = iw_q[15:9] == MNX_OP_MUL;
    assign iw_neg = iw_q[15:9] == MNX_OP_NEG;
    // operands are latched rather than read live, so a later change on
    // accum or mem_rdata cannot disturb a product in flight
    assign prod = {8'h00, acc_q} * {8'h00, opnd_q};
    // negation as inverse plus one; the ninth bit is the carry of the
    // implied zero minus operand, set only for a zero operand, and the
    // half carry comes from the low nibble alone
    assign neg_full = {1'b0, ~opnd_q} + 9'h001;
    assign neg_half = {1'b0, ~opnd_q[3:0]} + 5'h01;
    assign neg_res = neg_full[7:0];

    // strobes and the flag mask are pulses: zero unless set below
    always_comb begin
        ph_d = ph_q;
        iw_d = iw_q;
        addr_d = addr_q;
        opnd_d = opnd_q;
        acc_d = acc_q;
        busy_d = busy_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        done_d = 1'b0;
        wdat_d = wdat_q;
        ph_hi_d = ph_hi_q;
        pl_d = pl_q;
        fl_d = fl_q;
        fm_d = 5'h00;
        case (ph_q)
            MNX_Q1: begin
                // idle and undecoded words still run all phases, with no memory strobe
                if (instr_valid) begin
                    iw_d = instr_word;
                    addr_d = ea;
                    acc_d = accum;
                    busy_d = 1'b1;
                    rd_d = (is_mul || is_neg) && !is_idle;
                    ph_d = MNX_Q2;
                end
            end
            MNX_Q2: begin
                // memory answers in the read phase itself
                opnd_d = mem_rdata;
                ph_d = MNX_Q3;
            end
            MNX_Q3: begin
                // write data is registered so it stands with the write strobe
                if (iw_neg) begin
                    wr_d = 1'b1;
                    wdat_d = neg_res;
                end
                ph_d = MNX_Q4;
            end
            MNX_Q4: begin
                if (iw_mul) begin
                    ph_hi_d = prod[15:8];
                    pl_d = prod[7:0];
                end
                if (iw_neg) begin
                    fl_d[MNX_FLAG_C] = neg_full[8];
                    fl_d[MNX_FLAG_DC] = neg_half[4];
                    fl_d[MNX_FLAG_Z] = neg_res == 8'h00;
                    // signed wrap only for 80h, whose negation is itself
                    fl_d[MNX_FLAG_OV] = opnd_q == 8'h80;
                    fl_d[MNX_FLAG_N] = neg_res[7];
                    fm_d = 5'h1F;
                end
                done_d = 1'b1;
                busy_d = 1'b0;
                ph_d = MNX_Q1;
            end
            default: begin
                ph_d = MNX_Q1;
            end
        endcase
    end

    // ==========================================
    // registers
    // reset parks the sequencer in Q1 so a word may be taken at the
    // first edge after release
    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= MNX_Q1;
            iw_q <= MNX_OP_IDLE_ZERO;
            addr_q <= 12'h000;
            opnd_q <= MNX_PROD_RST;
            acc_q <= MNX_PROD_RST;
            busy_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            wdat_q <= MNX_PROD_RST;
            ph_hi_q <= MNX_PROD_RST;
            pl_q <= MNX_PROD_RST;
            fl_q <= MNX_FLAGS_RST;
            fm_q <= MNX_FLAGS_RST;
        end else begin
            ph_q <= ph_d;
            iw_q <= iw_d;
            addr_q <= addr_d;
            opnd_q <= opnd_d;
            acc_q <= acc_d;
            busy_q <= busy_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            done_q <= done_d;
            wdat_q <= wdat_d;
            ph_hi_q <= ph_hi_d;
            pl_q <= pl_d;
            fl_q <= fl_d;
            fm_q <= fm_d;
        end
    end

    // ==========================================
    // outputs, each straight from its register
    assign mem_addr = addr_q;
    assign mem_rd = rd_q;
    assign mem_wr = wr_q;
    assign mem_wdata = wdat_q;
    assign product_high_byte = ph_hi_q;
    assign product_low_byte = pl_q;
    assign flags = fl_q;
    assign flags_wr_mask = fm_q;
    assign phase = ph_q;
    assign instr_done = done_q;
endmodule
`default_nettype wire

// ===== rtl/mnx_pkg.sv
// constants and types for the multiply / negate / idle execution datapath
`default_nettype none
package mnx_pkg;
    // ==========================================
    // opcode fields
    localparam logic [6:0] MNX_OP_MUL = 7'h01;
    localparam logic [6:0] MNX_OP_NEG = 7'h36;
    localparam logic [3:0] MNX_OP_IDLE_HI = 4'hF;
    localparam logic [15:0] MNX_OP_IDLE_ZERO = 16'h0000;
    localparam int MNX_BANK_BIT = 8;
    localparam logic [7:0] MNX_INDEX_LIMIT = 8'h5F;
    // ==========================================
    // reset values
    localparam logic [7:0] MNX_PROD_RST = 8'h00;
    localparam logic [4:0] MNX_FLAGS_RST = 5'h00;
    localparam logic [1:0] MNX_PHASE_RST = 2'h0;
    // ==========================================
    // flag positions in the flag vector
    localparam int MNX_FLAG_C = 0;
    localparam int MNX_FLAG_DC = 1;
    localparam int MNX_FLAG_Z = 2;
    localparam int MNX_FLAG_OV = 3;
    localparam int MNX_FLAG_N = 4;
    // ==========================================
    // phases of the four-phase instruction cycle
    typedef enum logic [3:0] {
        MNX_Q1 = 4'b0001,
        MNX_Q2 = 4'b0010,
        MNX_Q3 = 4'b0100,
        MNX_Q4 = 4'b1000
    } mnx_phase_type;
    // ==========================================
    // operand addressing mode
    typedef enum logic [2:0] {
        MNX_AM_ACCESS = 3'b001,
        MNX_AM_BANKED = 3'b010,
        MNX_AM_INDEXED = 3'b100
    } mnx_amode_type;
endpackage
`default_nettype wire

// ===== dv/mnx_exec_checker.sv
// assertions on the multiply / negate / idle datapath ports
`default_nettype none
module mnx_exec_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [4:0] flags,
    input wire logic [4:0] flags_wr_mask,
    input wire logic [3:0] phase,
    input wire logic instr_done
);
    // ==========================================
    // kinds of instruction taken in Q1
    wire logic tk = phase == 4'h1 && instr_valid;
    wire logic mul = tk && instr_word[15:9] == 7'h01;
    wire logic neg = tk && instr_word[15:9] == 7'h36;
    wire logic idl = tk && (instr_word[15:12] == 4'hF || instr_word == 16'h0000);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_mul_reads: assert property (mul |=> mem_rd ##2 !mem_wr)
        else $error("multiply strobes wrong");
    a_mul_no_flags: assert property (mul |-> ##4 flags_wr_mask == 5'h00 && $stable(flags))
        else $error("multiply touched flags");
    a_neg_writes: assert property (neg |=> mem_rd ##2 mem_wr)
        else $error("negate strobes wrong");
    a_neg_flag_mask: assert property (neg |-> ##4 flags_wr_mask == 5'h1F)
        else $error("negate flags not written");
    a_idle_quiet: assert property (idl |=> (!mem_rd && !mem_wr) [*3])
        else $error("idle word accessed memory");
    a_read_in_q2: assert property (mem_rd |-> phase == 4'h2)
        else $error("read outside Q2");
    a_write_in_q4: assert property (mem_wr |-> phase == 4'h8)
        else $error("write outside Q4");
    a_done_after_q4: assert property (phase == 4'h8 |=> instr_done && phase == 4'h1)
        else $error("cycle did not complete");
endmodule
`default_nettype wire

// ===== dv/tb_mnx_exec.sv
// self-checking bench for the multiply / negate / idle datapath
`default_nettype none
module tb_mnx_exec;
    import mnx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, instr_valid = 0, extended_set = 0, mem_rd, mem_wr, instr_done;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] accum = 8'h00, mem_rdata = 8'h00, mem_wdata, product_high_byte, product_low_byte;
    logic [3:0] bank_pointer = 4'hA, phase;
    logic [11:0] index_base = 12'h200, mem_addr, ad_s;
    logic [4:0] flags, flags_wr_mask;
    logic rd_s, wr_s;
    int num_errors = 0, cmp_count = 0;
    mnx_exec mnx_exec_i (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .accum(accum), .bank_pointer(bank_pointer),
        .extended_set(extended_set), .index_base(index_base), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
        .flags(flags), .flags_wr_mask(flags_wr_mask), .phase(phase), .instr_done(instr_done));
    always #4 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one instruction: strobes sampled in Q2 and Q4, ends settled in the next Q1
    task automatic issue(input logic [15:0] w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (phase !== 4'h1 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 8) begin
            num_errors++;
            tally_and_finish();
        end
        instr_word = w;
        accum = a;
        mem_rdata = d;
        instr_valid = 1;
        @(posedge clk);
        #1 instr_valid = 0;
        rd_s = mem_rd;
        ad_s = mem_addr;
        repeat (2) @(posedge clk);
        #1 wr_s = mem_wr;
        @(posedge clk);
        #1 mem_rdata = ~d;
        chk(instr_done, 1);
    endtask
    task automatic t_mul();
        issue(16'h035C, 8'hC4, 8'hB5);
        chk(rd_s, 1);
        chk(ad_s, 12'hA5C);
        chk(wr_s, 0);
        chk({product_high_byte, product_low_byte}, 16'h8A94);
        issue(16'h0290, 8'hFF, 8'hFF);
        chk(ad_s, 12'hF90);
        chk({product_high_byte, product_low_byte}, 16'hFE01);
        issue(16'h0210, 8'h00, 8'h37);
        chk({product_high_byte, product_low_byte}, 16'h0000);
        chk(flags, 5'h00);
    endtask
    task automatic t_indexed();
        extended_set = 1;
        issue(16'h025F, 8'h02, 8'h03);
        chk(ad_s, 12'h25F);
        issue(16'h0260, 8'h02, 8'h03);
        chk(ad_s, 12'h060);
        extended_set = 0;
    endtask
    task automatic t_neg();
        logic [7:0] op [3] = '{8'h3A, 8'h80, 8'h00};
        logic [7:0] res [3] = '{8'hC6, 8'h80, 8'h00};
        logic [4:0] fl [3] = '{5'h10, 5'h1A, 5'h07};
        for (int i = 0; i < 3; i++) begin
            issue(16'h6D44, 8'h55, op[i]);
            chk(ad_s, 12'hA44);
            chk({rd_s, wr_s}, 2'h3);
            chk(mem_wdata, res[i]);
            chk(flags, fl[i]);
            chk(flags_wr_mask, 5'h1F);
        end
    endtask
    task automatic t_idle();
        logic [15:0] w [2] = '{16'h0000, 16'hF123};
        for (int i = 0; i < 2; i++) begin
            issue(w[i], 8'h11, 8'h22);
            chk({rd_s, wr_s, flags_wr_mask}, 7'h00);
            chk(flags, 5'h07);
            chk({product_high_byte, product_low_byte}, 16'h0006);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        chk(phase, 4'h1);
        t_mul();
        t_indexed();
        t_neg();
        t_idle();
        tally_and_finish();
    end
endmodule
bind mnx_exec mnx_exec_checker mnx_exec_checker_i (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .flags(flags), .flags_wr_mask(flags_wr_mask), .phase(phase), .instr_done(instr_done));
`default_nettype wire
